// file: bench/host_modem_model.sv
/* Host pin side and modem: chip selects, read strobes, pin address
   and the call-alert line. Assumes it shares clock_in with the design. */
`timescale 1ns/10ps
module host_modem_model (
  input wire clock_in, // Core clock
  input wire [7:0] data_in, // Data pins from the device
  input wire oe_n_in, // Device drives data while low
  output reg sel_a_out = 1'b0, // Select, high
  output reg sel_b_out = 1'b0, // Select, high
  output reg sel_c_n_out = 1'b1, // Select, low
  output reg rd_low_n_out = 1'b1, // Strobe, low
  output reg rd_high_out = 1'b0, // Strobe, high
  output reg [2:0] addr_out = 3'h0, // Address
  output reg alert_out = 1'b0 // Call alert
);
  task set_alert(input v);
  begin
    @(posedge clock_in);
    alert_out <= v;
  end
  endtask
  // Only one strobe moves; the other stays inactive all through
  task pin_read(input [2:0] a, input hi, input sel, output [7:0] d, output ok);
    int n;
  begin
    ok = 1'b0;
    d = 8'h00;
    @(posedge clock_in);
    sel_a_out <= 1'b1;
    sel_b_out <= 1'b1;
    sel_c_n_out <= !sel;
    addr_out <= a;
    rd_high_out <= hi;
    rd_low_n_out <= hi;
    for (n = 0; n < 10; n++)
    begin
      @(posedge clock_in);
      #1;
      if (!ok && oe_n_in === 1'b0)
      begin
        ok = 1'b1;
        d = data_in;
      end
    end
    @(posedge clock_in);
    sel_a_out <= 1'b0;
    sel_c_n_out <= 1'b1;
    rd_high_out <= 1'b0;
    rd_low_n_out <= 1'b1;
    repeat (4) @(posedge clock_in);
  end
  endtask
endmodule

// file: bench/test_uart_modem_io.sv
/* Self-checking bench for uart_modem_io.
   Assumes the design files and the register header compile first. */
`timescale 1ns/10ps
`include "uart_modem_regs.vh"
module test_uart_modem_io;
  logic clock_in;
  logic rst_in = 1'b1;
  logic master_clear_in = 1'b0;
  logic rx_thresh_in = 1'b0;
  logic [7:0] rx_data_in = 8'hA5;
  logic [2:0] bus_addr_in = 3'h0;
  logic [7:0] bus_wdata_in = 8'h00;
  logic bus_wr_in = 1'b0;
  logic bus_rd_in = 1'b0;
  wire select_high_a_in, select_high_b_in, select_low_c_n_in, read_low_n_in, read_high_in;
  wire [2:0] pin_addr_in;
  wire call_alert_in, data_oe_n_out, driver_disable_out, irq_out, send_permit_n_out;
  wire [7:0] bus_rdata_out, data_out;
  int errors = 0;
  int compares = 0;
  logic [7:0] got;
  logic ok;
  // Nibbles: control byte, threshold, expected send-permit pin
  logic [15:0] rows [6] = '{16'h0200, 16'h0001, 16'h1201, 16'h2200, 16'h2211, 16'h0210};
  uart_modem_io dut (.clock_in, .rst_in, .master_clear_in, .select_high_a_in,
    .select_high_b_in, .select_low_c_n_in, .read_low_n_in, .read_high_in, .pin_addr_in,
    .call_alert_in, .rx_thresh_in, .rx_data_in, .bus_addr_in, .bus_wdata_in, .bus_wr_in,
    .bus_rd_in, .bus_rdata_out, .data_out, .data_oe_n_out, .driver_disable_out, .irq_out,
    .send_permit_n_out);
  host_modem_model host (.clock_in, .data_in(data_out), .oe_n_in(data_oe_n_out),
    .sel_a_out(select_high_a_in), .sel_b_out(select_high_b_in),
    .sel_c_n_out(select_low_c_n_in), .rd_low_n_out(read_low_n_in),
    .rd_high_out(read_high_in), .addr_out(pin_addr_in), .alert_out(call_alert_in));
  task check(input string what, input [7:0] exp, input [7:0] seen);
  begin
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task wr(input [2:0] a, input [7:0] d);
  begin
    @(posedge clock_in);
    bus_addr_in <= a;
    bus_wdata_in <= d;
    bus_wr_in <= 1'b1;
    @(posedge clock_in);
    bus_wr_in <= 1'b0;
  end
  endtask
  task rd(input [2:0] a, input [7:0] exp);
  begin
    @(posedge clock_in);
    bus_addr_in <= a;
    bus_rd_in <= 1'b1;
    @(posedge clock_in);
    bus_rd_in <= 1'b0;
    #1;
    check("read data", exp, bus_rdata_out);
  end
  endtask
  task wait_irq(input v);
    int n;
  begin
    n = 0;
    while (irq_out !== v && n < 20)
    begin
      @(posedge clock_in);
      #1;
      n++;
    end
    check("irq", {7'h00, v}, {7'h00, irq_out});
    if (irq_out !== v)
      conclude();
  end
  endtask
  task conclude();
  begin
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  initial
  begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  initial
  begin
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    #1;
    check("reset pins", 8'h06, {5'h00, send_permit_n_out, data_oe_n_out, irq_out});
    check("reset disable", 8'h01, {7'h00, driver_disable_out});
    rd(`OFS_MODEM_CTRL, `RST_MODEM_CTRL);
    rd(`OFS_MASK, `RST_MASK);
    rd(`OFS_DATA, 8'hA5);
    wr(3'h3, 8'hFF);
    rd(3'h3, 8'h00);
    wr(`OFS_MODEM_STAT, 8'hFF);
    rd(`OFS_MODEM_STAT, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clock_in);
      rx_thresh_in <= rows[i][4];
      wr(`OFS_MODEM_CTRL, rows[i][15:8]);
      repeat (3) @(posedge clock_in);
      #1;
      check("send permit", {7'h00, rows[i][0]}, {7'h00, send_permit_n_out});
    end
    @(posedge clock_in);
    rx_thresh_in <= 1'b0;
    rd(`OFS_EVENT, 8'h02);
    wr(`OFS_MASK, 8'h01);
    host.set_alert(1'b1);
    wait_irq(1'b1);
    rd(`OFS_MODEM_STAT, 8'h44);
    rd(`OFS_MODEM_STAT, 8'h40);
    rd(`OFS_EVENT, 8'h01);
    wait_irq(1'b0);
    wr(`OFS_MASK, 8'h00);
    host.set_alert(1'b0);
    repeat (4) @(posedge clock_in);
    host.set_alert(1'b1);
    repeat (6) @(posedge clock_in);
    #1;
    check("masked irq", 8'h00, {7'h00, irq_out});
    rd(`OFS_MODEM_STAT, 8'h44);
    host.pin_read(`OFS_MODEM_CTRL, 1'b0, 1'b1, got, ok);
    check("pin read low", 8'h02, got);
    host.pin_read(`OFS_MODEM_CTRL, 1'b1, 1'b1, got, ok);
    check("pin read high", 8'h02, got);
    host.pin_read(`OFS_MODEM_CTRL, 1'b0, 1'b0, got, ok);
    check("pin deselected", 8'h00, {7'h00, ok});
    @(posedge clock_in);
    master_clear_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    #1;
    check("clear permit", 8'h01, {7'h00, send_permit_n_out});
    @(posedge clock_in);
    master_clear_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    rd(`OFS_MODEM_CTRL, `RST_MODEM_CTRL);
    // Pin still high: loop mode must take the level from the control bit instead
    wr(`OFS_MODEM_CTRL, 8'h10);
    wr(`OFS_MODEM_CTRL, 8'h14);
    rd(`OFS_MODEM_STAT, 8'h44);
    conclude();
  end
endmodule
bind uart_modem_io uart_modem_io_checker chk (.clock_in, .rst_in, .master_clear_in,
  .select_high_a_in, .select_high_b_in, .select_low_c_n_in, .read_low_n_in, .read_high_in,
  .call_alert_in, .bus_addr_in, .bus_wdata_in, .bus_wr_in, .bus_rd_in, .bus_rdata_out,
  .data_oe_n_out, .driver_disable_out, .irq_out, .send_permit_n_out);

// file: bench/uart_modem_io_checker.sv
/* Port assertions for uart_modem_io.
   Assumes the bench binds it to the design's top module. */
`timescale 1ns/10ps
module uart_modem_io_checker (
  input wire clock_in, // Clock
  input wire rst_in, // Reset
  input wire master_clear_in, // Pin
  input wire select_high_a_in, // Pin
  input wire select_high_b_in, // Pin
  input wire select_low_c_n_in, // Pin
  input wire read_low_n_in, // Pin
  input wire read_high_in, // Pin
  input wire call_alert_in, // Pin
  input wire [2:0] bus_addr_in, // Port
  input wire [7:0] bus_wdata_in, // Port
  input wire bus_wr_in, // Port
  input wire bus_rd_in, // Port
  input wire [7:0] bus_rdata_out, // Port
  input wire data_oe_n_out, // Pin
  input wire driver_disable_out, // Pin
  input wire irq_out, // Pin
  input wire send_permit_n_out // Pin
);
  wire sel = select_high_a_in & select_high_b_in & ~select_low_c_n_in;
  wire strobe = ~read_low_n_in | read_high_in;
  wire stat_rd = bus_rd_in && bus_addr_in == 3'h6;
  wire mask_off = bus_wr_in && bus_addr_in == 3'h1;
  // Loop mode takes the alert level from a control bit, so the pin says nothing then
  reg loop_on;
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      loop_on <= 1'b0;
    else if (master_clear_in)
      loop_on <= 1'b0;
    else if (bus_wr_in && bus_addr_in == 3'h4)
      loop_on <= bus_wdata_in[4];
  end
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  // Pin paths pass two sync flops, so four samples give a safe margin
  a_oe_ddis_same: assert property (data_oe_n_out == driver_disable_out)
    else $error("enable and disable differ");
  a_read_drives: assert property ((sel && strobe) [*4] |=> !data_oe_n_out)
    else $error("pin read not driven");
  a_deselect_quiet: assert property (!sel [*4] |=> data_oe_n_out)
    else $error("driven while deselected");
  a_clear_permit: assert property (master_clear_in [*4] |=> send_permit_n_out)
    else $error("permit active in clear");
  a_rdata_idle: assert property (!bus_rd_in |=> bus_rdata_out == 8'h00)
    else $error("read data outside slot");
  a_status_layout: assert property (stat_rd |=> (bus_rdata_out & 8'hBB) == 8'h00)
    else $error("status spare bits set");
  a_alert_level: assert property (call_alert_in [*4] ##0 (stat_rd && !loop_on)
    |=> bus_rdata_out[6])
    else $error("alert level not shown");
  a_mask_gates: assert property (mask_off && bus_wdata_in == 8'h00 ##1 !mask_off
    |=> !irq_out)
    else $error("masked interrupt");
  cover property (!data_oe_n_out);
  cover property ($rose(irq_out));
  cover property (!send_permit_n_out);
endmodule

// file: logic/sticky_flag.v
/*
  Sticky event flag: set by hardware, cleared by a read strobe.
  Assumes set and clear are one-cycle pulses on the same clock.
*/
`timescale 1ns/10ps
module sticky_flag (
  input wire clock_in, // Core clock
  input wire rst_in, // Asynchronous reset, active high
  input wire set_in, // Event pulse
  input wire clear_in, // Clear pulse from a register read
  output reg flag_out // Sticky flag
);

  // Set wins over clear so that an event in the clearing cycle survives
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      flag_out <= 1'b0;
    else if (set_in)
      flag_out <= 1'b1;
    else if (clear_in)
      flag_out <= 1'b0;
  end

endmodule

// file: logic/sync_bits.v
/*
  Two-stage synchroniser for a group of unrelated level inputs.
  Assumes each bit is a slow level; no bus coherence is implied.
*/
`timescale 1ns/10ps
module sync_bits #(
  parameter WIDTH = 1
)
(
  input wire clock_in, // Core clock
  input wire rst_in, // Asynchronous reset, active high
  input wire [WIDTH-1:0] async_in, // Levels from outside the clock domain
  output reg [WIDTH-1:0] sync_out // Levels after two flip-flops
);

  reg [WIDTH-1:0] stage_one;

  // Only the second stage reads the first
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stage_one <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule

// file: logic/uart_modem_io.v
/*
  Host read strobes, call-alert modem input and send-permit modem
  output of a serial port, with the modem control, modem status,
  event status and mask registers.
  Assumes the chip selects, read strobes, pin address, master clear
  and call-alert come from pins; rx_thresh_in, rx_data_in and the
  plain register port run on clock_in.
*/
// The address map and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "uart_modem_regs.vh"

module uart_modem_io (
  input wire clock_in, // Core clock, 200 MHz
  input wire rst_in, // Asynchronous reset, active high
  input wire master_clear_in, // Master clear pin, active high
  input wire select_high_a_in, // Chip select, active high
  input wire select_high_b_in, // Chip select, active high
  input wire select_low_c_n_in, // Chip select, active low
  input wire read_low_n_in, // Read strobe pin, active low
  input wire read_high_in, // Read strobe pin, active high
  input wire [2:0] pin_addr_in, // Register address pins
  input wire call_alert_in, // Call-alert modem input
  input wire rx_thresh_in, // Receive FIFO at threshold
  input wire [7:0] rx_data_in, // Receive data byte
  input wire [2:0] bus_addr_in, // Register port address
  input wire [7:0] bus_wdata_in, // Register port write data
  input wire bus_wr_in, // Register port write strobe
  input wire bus_rd_in, // Register port read strobe
  output reg [7:0] bus_rdata_out, // Register port read data
  output reg [7:0] data_out, // Data bus pins, output value
  output reg data_oe_n_out, // Data bus output enable, low drives
  output reg driver_disable_out, // High while no pin read runs
  output reg irq_out, // Interrupt, active high level
  output reg send_permit_n_out // Send-permit modem output, active low
);

  wire [7:0] pins_s;
  wire mclear_s;
  wire sel_a_s;
  wire sel_b_s;
  wire sel_c_n_s;
  wire rd_n_s;
  wire rd_s;
  wire alert_pin_s;
  wire [2:0] pin_addr_s;

  reg [7:0] modem_ctrl_reg;
  reg [7:0] mask_reg;
  reg alert_prev;
  reg thresh_prev;
  reg pin_rd_prev;

  wire call_alert_rise_flag;
  wire [`EV_WIDTH-1:0] event_flags;

  wire selected;
  wire pin_rd_active;
  wire pin_rd_start;
  wire alert_level;
  wire alert_rise;
  wire thresh_rise;
  wire loop_mode;
  wire auto_flow;
  wire stat_read;
  wire event_read;
  wire flag_clear;
  wire event_clear;
  wire [7:0] modem_stat;
  wire [7:0] event_byte;
  reg next_send_permit_n;

  // Pins are asynchronous to clock_in
  sync_bits #(
    .WIDTH(8)
  ) pin_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .async_in({master_clear_in, select_high_a_in, select_high_b_in,
      select_low_c_n_in, read_low_n_in, read_high_in, call_alert_in, 1'b0}),
    .sync_out(pins_s)
  );

  sync_bits #(
    .WIDTH(3)
  ) addr_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .async_in(pin_addr_in),
    .sync_out(pin_addr_s)
  );

  assign mclear_s = pins_s[7];
  assign sel_a_s = pins_s[6];
  assign sel_b_s = pins_s[5];
  assign sel_c_n_s = pins_s[4];
  assign rd_n_s = pins_s[3];
  assign rd_s = pins_s[2];
  assign alert_pin_s = pins_s[1];

  // Strobes count only with all three selects active
  assign selected = sel_a_s & sel_b_s & ~sel_c_n_s;
  // A strobe tied to its active level would hold the read for as long as all three selects stay active
  assign pin_rd_active = selected & (~rd_n_s | rd_s);
  assign pin_rd_start = pin_rd_active & ~pin_rd_prev;

  assign loop_mode = modem_ctrl_reg[`MC_LOOP];
  assign auto_flow = modem_ctrl_reg[`MC_AUTO_FLOW];

  // In loop mode the alert input follows the control bit, not the pin
  assign alert_level = loop_mode ? modem_ctrl_reg[`MC_LOOP_ALERT] : alert_pin_s;
  assign alert_rise = alert_level & ~alert_prev;
  assign thresh_rise = auto_flow & rx_thresh_in & ~thresh_prev;

  // A status read from either side clears the flags it shows
  assign stat_read = (bus_rd_in & (bus_addr_in == `OFS_MODEM_STAT)) |
    (pin_rd_start & (pin_addr_s == `OFS_MODEM_STAT));
  assign event_read = (bus_rd_in & (bus_addr_in == `OFS_EVENT)) |
    (pin_rd_start & (pin_addr_s == `OFS_EVENT));
  assign flag_clear = stat_read | mclear_s;
  assign event_clear = event_read | mclear_s;

  sticky_flag rise_flag (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .set_in(alert_rise),
    .clear_in(flag_clear),
    .flag_out(call_alert_rise_flag)
  );

  sticky_flag rise_event (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .set_in(alert_rise),
    .clear_in(event_clear),
    .flag_out(event_flags[`EV_ALERT_RISE])
  );

  sticky_flag thresh_event (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .set_in(thresh_rise),
    .clear_in(event_clear),
    .flag_out(event_flags[`EV_THRESH])
  );

  assign modem_stat = {1'b0, alert_level, 3'h0, call_alert_rise_flag, 2'h0};
  assign event_byte = {{(8 - `EV_WIDTH){1'b0}}, event_flags};

  // Register read multiplexer shared by both read paths
  function [7:0] read_mux;
    input [2:0] addr;
    begin
      case (addr)
        `OFS_DATA: read_mux = rx_data_in;
        `OFS_MASK: read_mux = mask_reg;
        `OFS_MODEM_CTRL: read_mux = modem_ctrl_reg;
        `OFS_MODEM_STAT: read_mux = modem_stat;
        `OFS_EVENT: read_mux = event_byte;
        default: read_mux = `RST_BYTE;
      endcase
    end
  endfunction

  // Edge history for rise detection
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      alert_prev <= 1'b0;
      thresh_prev <= 1'b0;
      pin_rd_prev <= 1'b0;
    end
    else
    begin
      alert_prev <= alert_level;
      thresh_prev <= auto_flow & rx_thresh_in;
      pin_rd_prev <= pin_rd_active;
    end
  end

  // Writable registers
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      modem_ctrl_reg <= `RST_MODEM_CTRL;
      mask_reg <= `RST_MASK;
    end
    else if (mclear_s)
    begin
      modem_ctrl_reg <= `RST_MODEM_CTRL;
      mask_reg <= `RST_MASK;
    end
    else if (bus_wr_in)
    begin
      if (bus_addr_in == `OFS_MODEM_CTRL)
        modem_ctrl_reg <= bus_wdata_in;
      if (bus_addr_in == `OFS_MASK)
        mask_reg <= {{(8 - `EV_WIDTH){1'b0}}, bus_wdata_in[`EV_WIDTH-1:0]};
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      bus_rdata_out <= `RST_BYTE;
    else if (bus_rd_in)
      bus_rdata_out <= read_mux(bus_addr_in);
    else
      bus_rdata_out <= `RST_BYTE;
  end

  // Pin read path: data follows the addressed register while the strobe lasts
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      data_out <= `RST_BYTE;
      data_oe_n_out <= 1'b1;
      driver_disable_out <= 1'b1;
    end
    else
    begin
      data_oe_n_out <= ~pin_rd_active;
      driver_disable_out <= ~pin_rd_active;
      if (pin_rd_active)
        data_out <= read_mux(pin_addr_s);
      else
        data_out <= `RST_BYTE;
    end
  end

  // Interrupt is a level while any unmasked event stays set
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(event_flags & mask_reg[`EV_WIDTH-1:0]);
  end

  // Send-permit: every inactive cause overrides the control bit
  always @*
  begin
    next_send_permit_n = ~modem_ctrl_reg[`MC_SEND_PERMIT];
    if (mclear_s | loop_mode)
      next_send_permit_n = 1'b1;
    if (auto_flow & rx_thresh_in)
      next_send_permit_n = 1'b1;
  end

  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      send_permit_n_out <= 1'b1;
    else
      send_permit_n_out <= next_send_permit_n;
  end

endmodule

// file: pkg/uart_modem_regs.vh
/*
  Register offsets, field positions and reset values for the
  read-strobe, call-alert and send-permit part of the serial port.
  Assumes a 3-bit register address and 8-bit register data.
*/
`ifndef UART_MODEM_REGS_VH
`define UART_MODEM_REGS_VH

// Register offsets
`define OFS_DATA 3'h0
`define OFS_MASK 3'h1
`define OFS_MODEM_CTRL 3'h4
`define OFS_MODEM_STAT 3'h6
`define OFS_EVENT 3'h7

// Modem control fields
`define MC_SEND_PERMIT 1
`define MC_LOOP_ALERT 2
`define MC_LOOP 4
`define MC_AUTO_FLOW 5

// Modem status fields
`define MS_ALERT_RISE 2
`define MS_ALERT_LEVEL 6

// Event status and mask fields
`define EV_ALERT_RISE 0
`define EV_THRESH 1
`define EV_WIDTH 2

// Reset values
`define RST_MODEM_CTRL 8'h00
`define RST_MASK 8'h00
`define RST_BYTE 8'h00

`endif
